// ===== bdsr_host.sv
// Host-side model: debug command engine driving register accesses and events.
// Assumes a free-running ref_clk; every request is driven at the falling edge.
`default_nettype none
module bdsr_host
(
   // Toward the block
   output var bdsr_pkg::bdsr_acc_t acc,
   output var bdsr_pkg::bdsr_src_t acc_src,
   output var bdsr_pkg::bdsr_evt_t evt,
   // From the block
   input wire logic ref_clk,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus at time zero
   initial
   begin
      acc = '0;
      acc_src = bdsr_pkg::BDSR_SRC_HW;
      evt = '0;
   end
   // One register command; stale data inverted so nothing relies on it
   task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(negedge ref_clk);
      acc = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge ref_clk);
      acc.wr = 1'b0;
      acc.rd = 1'b0;
      acc.wdata = ~d;
      q = rdata;
   endtask : xfer
   // One-cycle event pulse
   task automatic pulse(input bdsr_pkg::bdsr_evt_t e);
      @(negedge ref_clk);
      evt = e;
      @(negedge ref_clk);
      evt = '0;
   endtask : pulse
endmodule : bdsr_host
`default_nettype wire

// ===== bdsr_page_reg.sv
// Program page register with paging route for debug memory accesses.
// Assumes the main block gates writes by security and decodes the address.
`default_nettype none
`include "bdsr_regs.svh"
module bdsr_page_reg
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Register write
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   // Memory access routing
   input wire logic mem_is_bd_cmd,
   output logic [7:0] page_reg_q,
   output logic paged_access,
   output logic [3:0] page_index_field
);
   logic [7:0] page_reg;

   // ==========================================================
   // Storage; unimplemented bits 6..4 stay zero
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         page_reg <= 8'h00;
      else if (wr_en)
         page_reg <= {wdata[7], 3'h0, wdata[3:0]};
   end

   // Register-space commands bypass paging
   assign paged_access = page_reg[`BDSR_PPR_PAE] & ~mem_is_bd_cmd;
   assign page_index_field = page_reg[3:0];
   assign page_reg_q = page_reg;
endmodule : bdsr_page_reg
`default_nettype wire

// ===== bdsr_pkg.sv
// Types shared by the debug status register block.
// Assumes the constants header is available by bare name.
`default_nettype none
package bdsr_pkg;
   // Register access from the debug command engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [17:0] addr;
      logic [7:0] wdata;
   } bdsr_acc_t;

   // Events from the command engine and the firmware
   typedef struct packed {
      logic cmd_rcvd;
      logic data_done;
      logic trace_cmd;
      logic resume_cmd;
      logic enter;
      logic exit_store;
      logic verify_done;
      logic verify_pass;
   } bdsr_evt_t;

   // Access origin
   typedef enum logic [1:0] {
      BDSR_SRC_HW = 2'b00,
      BDSR_SRC_STD_FW = 2'b01,
      BDSR_SRC_SEC_FW = 2'b10
   } bdsr_src_t;

   // Secure boot progress
   typedef enum logic [1:0] {
      BDSR_SEC_IDLE = 2'b00,
      BDSR_SEC_VERIFY = 2'b01,
      BDSR_SEC_OPEN = 2'b10,
      BDSR_SEC_LOCKED = 2'b11
   } bdsr_sec_t;
endpackage : bdsr_pkg
`default_nettype wire

// ===== bdsr_regs.svh
// Constants for the background debug status, saved condition code and page registers.
// Assumes inclusion by bare name from the page register and status design files.
`ifndef BDSR_REGS_SVH
`define BDSR_REGS_SVH

// ==========================================================
// Offsets
`define BDSR_ADDR_STATUS 18'h3FF01
`define BDSR_ADDR_CCR 18'h3FF06
`define BDSR_ADDR_PAGE 18'h3FF08

// ==========================================================
// Field positions
`define BDSR_STS_ENABLE 7
`define BDSR_STS_ACTIVE 6
`define BDSR_STS_SDV 4
`define BDSR_STS_TRACE 3
`define BDSR_STS_UNSECURE_FLAG 1
`define BDSR_PPR_PAE 7

// ==========================================================
// Reset values
`define BDSR_CCR_RST_SSC 8'hD8
`define BDSR_CCR_RST_OTHER 8'h00

`endif

// ===== bdsr_status.sv
// Debug status, saved condition codes and page registers of the debug unit.
// Assumes the command engine, firmware and flash verify drive one-cycle event pulses.
`default_nettype none
`include "bdsr_regs.svh"
module bdsr_status
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Mode and security straps
   input wire logic special_single_chip,
   input wire logic flash_secured,
   // Register access
   input wire bdsr_pkg::bdsr_acc_t acc,
   input wire bdsr_pkg::bdsr_src_t acc_src,
   output logic [7:0] rdata,
   // Events
   input wire bdsr_pkg::bdsr_evt_t evt,
   input wire logic [7:0] cpu_ccr,
   input wire logic mem_is_bd_cmd,
   // Status outputs
   output logic debug_enable_flag,
   output logic debug_active_flag,
   output logic std_table_mapped,
   output logic sec_table_mapped,
   output logic security_on,
   output logic paged_access,
   output logic [3:0] page_index_field
);
   logic [7:0] ccr_reg;
   logic [7:0] ccr_next;
   logic enable_reg;
   logic active_reg;
   logic sdv_reg;
   logic trace_reg;
   logic unsecure_flag_reg;
   logic secured_reg;
   logic [7:0] page_q;
   logic [7:0] rdata_next;
   logic not_secure;
   logic wr_sts;
   logic wr_ccr;
   logic wr_page;
   bdsr_pkg::bdsr_sec_t sec_reg;

   // ==========================================================
   // Security view; strap sampled on the clock, not by reset
   // Unsecure has no meaning when the flash byte is already unsecured
   assign not_secure = ~secured_reg | unsecure_flag_reg;
   assign security_on = ~not_secure;

   // Writes allowed only while unsecured, except secure firmware writes to status
   assign wr_sts = acc.wr && acc.addr == `BDSR_ADDR_STATUS
      && (not_secure || acc_src == bdsr_pkg::BDSR_SRC_SEC_FW);
   assign wr_ccr = acc.wr && acc.addr == `BDSR_ADDR_CCR && not_secure;
   assign wr_page = acc.wr && acc.addr == `BDSR_ADDR_PAGE && not_secure;

   // Security latched in the idle cycle after each reset; resecure comes back next reset
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         secured_reg <= 1'b1;
      else if (sec_reg == bdsr_pkg::BDSR_SEC_IDLE)
         secured_reg <= flash_secured;
   end

   // ==========================================================
   // Secure boot sequence
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         sec_reg <= bdsr_pkg::BDSR_SEC_IDLE;
      else
      begin
         case (sec_reg)
            bdsr_pkg::BDSR_SEC_IDLE:
               if (special_single_chip && flash_secured)
                  sec_reg <= bdsr_pkg::BDSR_SEC_VERIFY;
               else
                  sec_reg <= bdsr_pkg::BDSR_SEC_OPEN;
            bdsr_pkg::BDSR_SEC_VERIFY:
               if (evt.verify_done)
                  sec_reg <= evt.verify_pass ? bdsr_pkg::BDSR_SEC_OPEN
                     : bdsr_pkg::BDSR_SEC_LOCKED;
            default:
               sec_reg <= sec_reg;
         endcase
      end
   end

   // Secure table overlays the standard one until verify completes, pass or fail
   assign sec_table_mapped = (sec_reg == bdsr_pkg::BDSR_SEC_VERIFY);
   assign std_table_mapped = active_reg & ~sec_table_mapped;

   // ==========================================================
   // Enable flag
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         enable_reg <= 1'b0;
      else if (sec_reg == bdsr_pkg::BDSR_SEC_IDLE)
         enable_reg <= special_single_chip && !flash_secured;
      else if (sec_reg == bdsr_pkg::BDSR_SEC_VERIFY)
         enable_reg <= evt.verify_done;
      else if (wr_sts)
         enable_reg <= acc.wdata[`BDSR_STS_ENABLE];
   end

   // ==========================================================
   // Active flag: set by entry only when enabled, cleared by exit store from standard firmware
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         active_reg <= 1'b0;
      else if (evt.enter && enable_reg)
         active_reg <= 1'b1;
      else if (evt.exit_store && acc_src == bdsr_pkg::BDSR_SRC_STD_FW)
         active_reg <= 1'b0;
   end

   // ==========================================================
   // Shift data valid: set wins over a clear in the same cycle
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         sdv_reg <= 1'b0;
      else if (evt.data_done)
         sdv_reg <= 1'b1;
      // Command received or a real exit clears it; a refused exit store leaves the data phase intact
      else if (evt.cmd_rcvd || (evt.exit_store && active_reg
         && acc_src == bdsr_pkg::BDSR_SRC_STD_FW))
         sdv_reg <= 1'b0;
   end

   // ==========================================================
   // Trace flag
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         trace_reg <= 1'b0;
      else if (evt.trace_cmd && active_reg)
         trace_reg <= 1'b1;
      else if (evt.resume_cmd)
         trace_reg <= 1'b0;
   end

   // ==========================================================
   // Unsecure flag: zero entering secure mode, set on erased flash
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         unsecure_flag_reg <= 1'b0;
      else if (sec_reg == bdsr_pkg::BDSR_SEC_VERIFY && evt.verify_done)
         unsecure_flag_reg <= evt.verify_pass;
      else if (wr_sts && (!secured_reg || (special_single_chip
         && acc_src == bdsr_pkg::BDSR_SRC_SEC_FW)))
         unsecure_flag_reg <= acc.wdata[`BDSR_STS_UNSECURE_FLAG];
   end

   // ==========================================================
   // Saved condition codes; mode picks the reset image
   always_comb
   begin
      ccr_next = ccr_reg;
      if (sec_reg == bdsr_pkg::BDSR_SEC_IDLE)
         ccr_next = special_single_chip ? `BDSR_CCR_RST_SSC : `BDSR_CCR_RST_OTHER;
      else if (evt.enter && enable_reg && !active_reg)
         ccr_next = cpu_ccr;
      else if (wr_ccr)
         ccr_next = acc.wdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         ccr_reg <= `BDSR_CCR_RST_OTHER;
      else
         ccr_reg <= ccr_next;
   end

   // ==========================================================
   // Page register
   bdsr_page_reg u_page
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .wr_en(wr_page),
      .wdata(acc.wdata),
      .mem_is_bd_cmd(mem_is_bd_cmd),
      .page_reg_q(page_q),
      .paged_access(paged_access),
      .page_index_field(page_index_field)
   );

   // ==========================================================
   // Read mux; secured reads show zero except status
   always_comb
   begin
      rdata_next = 8'h00;
      if (acc.addr == `BDSR_ADDR_STATUS)
         rdata_next = {enable_reg, active_reg, 1'b0, sdv_reg, trace_reg, 1'b0,
            unsecure_flag_reg, 1'b0};
      else if (acc.addr == `BDSR_ADDR_CCR && not_secure)
         rdata_next = ccr_reg;
      else if (acc.addr == `BDSR_ADDR_PAGE && not_secure)
         rdata_next = page_q;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         rdata <= 8'h00;
      else if (acc.rd)
         rdata <= rdata_next;
   end

   assign debug_enable_flag = enable_reg;
   assign debug_active_flag = active_reg;
endmodule : bdsr_status
`default_nettype wire

// ===== bdsr_status_asserts.sv
// Checker on the ports of the debug status block.
// Assumes it is bound onto bdsr_status, one clock domain.
`default_nettype none
module bdsr_status_asserts
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Inputs watched
   input wire bdsr_pkg::bdsr_acc_t acc,
   input wire bdsr_pkg::bdsr_src_t acc_src,
   input wire bdsr_pkg::bdsr_evt_t evt,
   input wire logic mem_is_bd_cmd,
   // Outputs watched
   input wire logic debug_enable_flag,
   input wire logic debug_active_flag,
   input wire logic std_table_mapped,
   input wire logic sec_table_mapped,
   input wire logic security_on,
   input wire logic paged_access,
   input wire logic [3:0] page_index_field
);
   default clocking
      @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   // Entry only when enabled, and only through the entry event
   property p_enter;
      evt.enter && debug_enable_flag |=> debug_active_flag;
   endproperty
   a_enter: assert property (p_enter) else $error("enter missed");
   property p_noen;
      evt.enter && !debug_enable_flag && !debug_active_flag |=> !debug_active_flag;
   endproperty
   a_noen: assert property (p_noen) else $error("entered while disabled");
   property p_rose;
      $rose(debug_active_flag) |-> $past(evt.enter);
   endproperty
   a_rose: assert property (p_rose) else $error("active without entry");
   // Exit needs the standard firmware store
   property p_hold;
      debug_active_flag && !(evt.exit_store && acc_src == bdsr_pkg::BDSR_SRC_STD_FW)
         |=> debug_active_flag;
   endproperty
   a_hold: assert property (p_hold) else $error("active dropped");
   property p_map;
      debug_active_flag |-> std_table_mapped;
   endproperty
   a_map: assert property (p_map) else $error("table not mapped");
   property p_bdcmd;
      mem_is_bd_cmd |-> !paged_access;
   endproperty
   a_bdcmd: assert property (p_bdcmd) else $error("paged register command");
   property p_sec;
      sec_table_mapped |-> security_on;
   endproperty
   a_sec: assert property (p_sec) else $error("secure table while open");
   property p_verify;
      sec_table_mapped && !debug_enable_flag && !evt.verify_done |=> !debug_enable_flag;
   endproperty
   a_verify: assert property (p_verify) else $error("enable before verify");
   property p_page;
      !$stable(page_index_field) |-> $past(acc.wr) && $past(acc.addr) == 18'h3FF08;
   endproperty
   a_page: assert property (p_page) else $error("page changed without write");
endmodule : bdsr_status_asserts
bind bdsr_status bdsr_status_asserts chk_i (.ref_clk(ref_clk), .rst_b(rst_b), .acc(acc),
   .acc_src(acc_src), .evt(evt), .mem_is_bd_cmd(mem_is_bd_cmd),
   .debug_enable_flag(debug_enable_flag), .debug_active_flag(debug_active_flag),
   .std_table_mapped(std_table_mapped), .sec_table_mapped(sec_table_mapped),
   .security_on(security_on), .paged_access(paged_access),
   .page_index_field(page_index_field));
`default_nettype wire

// ===== debug_mode_status_registers_tb.sv
// Self-checking bench for the debug status block.
// Assumes the host model and checker are compiled alongside.
`default_nettype none
module debug_mode_status_registers_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ssc = 1'b0;
   logic sec = 1'b0;
   logic mem_is_bd_cmd = 1'b0;
   logic [7:0] cpu_ccr = 8'h00;
   logic [7:0] rdata, q;
   bdsr_pkg::bdsr_acc_t acc;
   bdsr_pkg::bdsr_src_t acc_src;
   bdsr_pkg::bdsr_evt_t evt;
   logic en, act, std_m, sec_m, sec_on, paged;
   logic [3:0] pidx;
   int bad_count = 0;
   int checks_done = 0;
   // Rows: address, write data, read-back
   logic [33:0] rows [4] = '{{18'h3FF06, 8'hA5, 8'hA5}, {18'h3FF08, 8'h03, 8'h03},
      {18'h3FF00, 8'hFF, 8'h00}, {18'h3FF08, 8'hFF, 8'h8F}};
   // Event rows: pulse, status read-back; second row has data done beat command received
   logic [15:0] ev_rows [5] = '{{8'h40, 8'hD0}, {8'hC0, 8'hD0}, {8'h80, 8'hC0},
      {8'h20, 8'hC8}, {8'h10, 8'hC0}};
   // 250 MHz
   always #2 ref_clk = ~ref_clk;
   bdsr_host host (.acc(acc), .acc_src(acc_src), .evt(evt), .ref_clk(ref_clk), .rdata(rdata));
   bdsr_status uut (.ref_clk(ref_clk), .rst_b(rst_b), .special_single_chip(ssc),
      .flash_secured(sec), .acc(acc), .acc_src(acc_src), .rdata(rdata), .evt(evt),
      .cpu_ccr(cpu_ccr), .mem_is_bd_cmd(mem_is_bd_cmd), .debug_enable_flag(en),
      .debug_active_flag(act), .std_table_mapped(std_m), .sec_table_mapped(sec_m),
      .security_on(sec_on), .paged_access(paged), .page_index_field(pidx));
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   // Three-cycle reset, straps held, one edge for strap sampling
   task automatic do_reset(input logic s, input logic f);
      rst_b = 1'b0;
      ssc = s;
      sec = f;
      repeat (3) @(negedge ref_clk);
      rst_b = 1'b1;
      @(negedge ref_clk);
   endtask : do_reset
   // Hang guard at 5000 cycles, far beyond the fewer than 100 cycles needed
   initial
   begin
      #20000;
      bad_count++;
      close_out();
   end
   initial
   begin
      do_reset(1'b1, 1'b0);
      chk("enable", en, 8'h01);
      host.xfer(1'b0, 18'h3FF06, 8'h00, q);
      chk("ccr_reset", q, 8'hD8);
      cpu_ccr = 8'h5A;
      host.pulse(8'h08);
      chk("active", act, 8'h01);
      chk("std_map", std_m, 8'h01);
      host.xfer(1'b0, 18'h3FF06, 8'h00, q);
      chk("ccr_saved", q, 8'h5A);
      foreach (rows[i])
      begin
         host.xfer(1'b1, rows[i][33:16], rows[i][15:8], q);
         host.xfer(1'b0, rows[i][33:16], 8'h00, q);
         chk("readback", q, rows[i][7:0]);
         if (rows[i][33:16] == 18'h3FF08)
         begin
            chk("page_idx", pidx, rows[i][3:0]);
            chk("paged", paged, rows[i][7]);
         end
      end
      mem_is_bd_cmd = 1'b1;
      @(negedge ref_clk);
      chk("bd_paged", paged, 8'h00);
      mem_is_bd_cmd = 1'b0;
      foreach (ev_rows[i])
      begin
         host.pulse(ev_rows[i][15:8]);
         host.xfer(1'b0, 18'h3FF01, 8'h00, q);
         chk("status_evt", q, ev_rows[i][7:0]);
      end
      host.pulse(8'h40);
      host.pulse(8'h04);
      chk("hw_exit", act, 8'h01);
      host.xfer(1'b0, 18'h3FF01, 8'h00, q);
      chk("sdv_kept", q, 8'hD0);
      host.acc_src = bdsr_pkg::BDSR_SRC_STD_FW;
      host.pulse(8'h04);
      chk("fw_exit", act, 8'h00);
      host.xfer(1'b0, 18'h3FF01, 8'h00, q);
      chk("sdv_exit", q, 8'h80);
      host.acc_src = bdsr_pkg::BDSR_SRC_HW;
      $display("open special chip test done");
      do_reset(1'b0, 1'b0);
      host.xfer(1'b0, 18'h3FF06, 8'h00, q);
      chk("ccr_other", q, 8'h00);
      host.pulse(8'h08);
      chk("no_entry", act, 8'h00);
      $display("normal mode test done");
      do_reset(1'b1, 1'b1);
      chk("sec_map", sec_m, 8'h01);
      chk("en_verify", en, 8'h00);
      host.xfer(1'b0, 18'h3FF06, 8'h00, q);
      chk("ccr_locked", q, 8'h00);
      host.pulse(8'h02);
      chk("en_after", en, 8'h01);
      chk("still_sec", sec_on, 8'h01);
      host.xfer(1'b1, 18'h3FF01, 8'h82, q);
      chk("hw_unsecure_flag", sec_on, 8'h01);
      host.acc_src = bdsr_pkg::BDSR_SRC_SEC_FW;
      host.xfer(1'b1, 18'h3FF01, 8'h82, q);
      chk("fw_unsecure_flag", sec_on, 8'h00);
      host.acc_src = bdsr_pkg::BDSR_SRC_HW;
      $display("failed erase test done");
      do_reset(1'b1, 1'b1);
      host.pulse(8'h03);
      chk("sec_unmap", sec_m, 8'h00);
      chk("sec_off", sec_on, 8'h00);
      host.xfer(1'b0, 18'h3FF01, 8'h00, q);
      chk("status", q, 8'h82);
      $display("erased flash test done");
      close_out();
   end
endmodule : debug_mode_status_registers_tb
`default_nettype wire
